/* File: src/lps_pkg.sv */
package lps_pkg;

    localparam int NPROG = 12;
    localparam int NSTEP = 10;
    localparam int NCH   = 8;
    localparam int NSLOT = 120;

    // Register byte offsets.
    localparam logic [7:0] A_CTRL       = 8'h00;
    localparam logic [7:0] A_ACTIVE     = 8'h04;
    localparam logic [7:0] A_CHAIN_ST   = 8'h08;
    localparam logic [7:0] A_STEP_IDX   = 8'h0c;
    localparam logic [7:0] A_STEP_W0    = 8'h10;
    localparam logic [7:0] A_STEP_W1    = 8'h14;
    localparam logic [7:0] A_STEP_W2    = 8'h18;
    localparam logic [7:0] A_STATUS     = 8'h1c;
    localparam logic [7:0] A_CHAIN_NEXT = 8'h40;

    // Control register bits; all but LIMIT_EN are self-clearing commands.
    localparam int C_RUN      = 0;
    localparam int C_CONT     = 1;
    localparam int C_STOP     = 2;
    localparam int C_PDEF     = 3;
    localparam int C_CDEF     = 4;
    localparam int C_LIMIT_EN = 5;

    // Status register bits and fields.
    localparam int S_BUSY    = 0;
    localparam int S_WAIT    = 1;
    localparam int S_OFFPH   = 2;
    localparam int S_REFUSED = 3;
    localparam int S_PROG_LO = 8;
    localparam int S_STEP_LO = 12;

    // Step word field positions.
    localparam int W0_SLOT_LO = 0;
    localparam int W0_RUN_LO  = 8;
    localparam int W0_SHCH_LO = 12;
    localparam int W1_OFF_LO  = 16;
    localparam int W2_PF_LO   = 16;

    // Reset values.
    localparam logic [7:0] ACTIVE_RST = 8'h00;
    localparam logic [3:0] CHAIN_ST_RST = 4'h0;
    localparam logic [3:0] SUCC_NONE = 4'h0;

    // Run selector encodings.
    localparam logic [1:0] RUN_SKIP   = 2'h0;
    localparam logic [1:0] RUN_AUTO   = 2'h1;
    localparam logic [1:0] RUN_MANUAL = 2'h2;

    // Timing: times are held in tenths of a second.
    localparam int CLK_NS       = 8;
    localparam int TENTH_NS     = 100_000_000;
    localparam int TICK_CYCLES  = TENTH_NS / CLK_NS;
    localparam logic [9:0] TIME_MIN = 10'h001;
    localparam logic [9:0] TIME_MAX = 10'h258;
    localparam logic [6:0] SLOT_MIN = 7'h01;
    localparam logic [6:0] SLOT_MAX = 7'h78;
    localparam logic [3:0] SHCH_MAX = 4'h8;

    typedef struct packed {
        logic [6:0] slot;
        logic [1:0] run;
        logic [3:0] shch;
        logic [9:0] on_t;
        logic [9:0] off_t;
        logic [9:0] short_t;
        logic [9:0] pf_t;
    } lps_step_s;

    typedef struct packed {
        logic [NCH-1:0] load_en;
        logic [NCH-1:0] short_en;
        logic [6:0]     settings_slot;
        logic           judge_window;
        logic           judge_strobe;
    } lps_chan_s;

endpackage

/* File: src/lps_tick.sv */
`timescale 1ns/10ps
module lps_tick #(
    parameter int CYCLES = 12_500_000
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic clr,
    output logic      tick
);

    // Restarting on clr keeps every step's first tenth a full tenth.
    logic [23:0] count;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= 24'h000000;
            tick  <= 1'b0;
        end else if (ce) begin
            if (clr) begin
                count <= 24'h000000;
                tick  <= 1'b0;
            end else if (count == 24'(CYCLES - 1)) begin
                count <= 24'h000000;
                tick  <= 1'b1;
            end else begin
                count <= count + 24'h000001;
                tick  <= 1'b0;
            end
        end
    end

endmodule

/* File: src/lps_seq.sv */
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
// Functional notes
// - Twelve programs of ten steps each are stored, 120 steps in all.
// - Steps of a program run in ascending order, first to tenth.
// - Each step names settings slot 1 to 120; slots may be reused.
// - Run selector: skip passes over, auto starts, manual waits continue.
// - On-time loads all active channels, 0.1 to 60.0 s.
// - Optional off-time 0.1 to 60.0 s follows on-time, load removed.
// - Short window starts with on-time and lasts its duration.
// - Short duration never exceeds the step on-time.
// - Judgement delay off or 0.1 s up to on plus off minus 0.1 s.
// - Limit check without judgement delay spans the whole step.
// - Step shorts one channel 1 to 8 or none.
// - All channels load together unless excluded.
// - Chain start program is any of programs 1 to 12.
// - Each program has a successor or none; chains in any order.
// - Chain stops at a none successor; back references loop forever.
// - Chain defaults: start program 1, all successors none.
// - Active mask per channel gates loading; all inactive at reset.
// - Run is refused while the active mask is empty.
// - Program defaults clear step data, saved setups untouched.
// - Stop aborts a running program at once.
module lps_seq
    import lps_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        op_run,
    input  wire logic        op_continue,
    input  wire logic        op_stop,
    output lps_chan_s        chan_ctl,
    output logic             busy
);

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_FETCH = 5'b00010,
        ST_WAIT  = 5'b00100,
        ST_ON    = 5'b01000,
        ST_OFF   = 5'b10000
    } lps_state_e;

    ////////////////////////////////////////////////////////////////////////
    logic       rst_s1;
    logic       rst_n;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_d;
    logic [2:0] pin_rise;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
            pin_d  <= 3'h0;
        end else if (ce) begin
            pin_s1 <= {op_stop, op_continue, op_run};
            pin_s2 <= pin_s1;
            pin_d  <= pin_s2;
        end
    end

    assign pin_rise = pin_s2 & ~pin_d;

    ////////////////////////////////////////////////////////////////////////
    lps_step_s      steps [NSLOT];
    logic [3:0]     succ [NPROG];
    logic [3:0]     chain_start;
    logic [NCH-1:0] active;
    logic           limit_en;
    logic [6:0]     step_idx;
    logic           refused;
    lps_state_e     state;
    logic [3:0]     prog;
    logic [3:0]     step;
    logic [10:0]    t;
    logic           tick;
    lps_step_s      cur;

    logic        wr;
    logic        setup;
    logic [31:0] ctrl_wd;
    logic        cmd_run;
    logic        cmd_cont;
    logic        cmd_stop;
    logic        succ_hit;
    logic [3:0]  succ_sel;

    assign wr    = psel & penable & pwrite & ce;
    assign setup = psel & ~penable & ce;
    assign ctrl_wd = (wr && paddr == A_CTRL) ? pwdata : 32'h00000000;
    assign cmd_run  = ctrl_wd[C_RUN] | pin_rise[0];
    assign cmd_cont = ctrl_wd[C_CONT] | pin_rise[1];
    assign cmd_stop = ctrl_wd[C_STOP] | pin_rise[2];
    assign succ_hit = paddr >= A_CHAIN_NEXT && paddr[1:0] == 2'h0
                      && paddr < A_CHAIN_NEXT + 8'(4 * NPROG);
    assign succ_sel = 4'((paddr - A_CHAIN_NEXT) >> 2);

    function automatic logic [9:0] clamp_t(input logic [9:0] v,
                                           input logic [9:0] hi);
        if (v == 10'h000) begin
            clamp_t = 10'h000;
        end else if (v > hi) begin
            clamp_t = hi;
        end else begin
            clamp_t = v;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Step storage, written indirectly through the step index register.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            step_idx <= 7'h00;
        end else if (wr && paddr == A_STEP_IDX) begin
            step_idx <= (pwdata[6:0] >= 7'(NSLOT)) ? 7'(NSLOT - 1)
                                                   : pwdata[6:0];
        end
    end

    always_ff @(posedge clock) begin
        if (wr && paddr == A_CTRL && pwdata[C_PDEF]) begin
            for (int i = 0; i < NSLOT; i++) begin
                steps[i] <= '0;
            end
        end else if (wr && paddr == A_STEP_W0) begin
            steps[step_idx].slot <= (pwdata[6:0] < SLOT_MIN) ? SLOT_MIN :
                (pwdata[6:0] > SLOT_MAX) ? SLOT_MAX : pwdata[6:0];
            steps[step_idx].run <= (pwdata[9:8] > RUN_MANUAL) ? RUN_MANUAL
                                   : pwdata[9:8];
            steps[step_idx].shch <= (pwdata[15:12] > SHCH_MAX) ? SHCH_MAX
                                    : pwdata[15:12];
        end else if (wr && paddr == A_STEP_W1) begin
            steps[step_idx].on_t <= (pwdata[9:0] == 10'h000) ? TIME_MIN
                : clamp_t(pwdata[9:0], TIME_MAX);
            steps[step_idx].off_t <= clamp_t(pwdata[25:16], TIME_MAX);
        end else if (wr && paddr == A_STEP_W2) begin
            steps[step_idx].short_t <= clamp_t(pwdata[9:0], TIME_MAX);
            steps[step_idx].pf_t <= clamp_t(pwdata[25:16], 10'h3ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Chain table, active mask and limit enable.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            chain_start <= CHAIN_ST_RST;
            for (int i = 0; i < NPROG; i++) begin
                succ[i] <= SUCC_NONE;
            end
        end else if (wr && paddr == A_CTRL && pwdata[C_CDEF]) begin
            chain_start <= CHAIN_ST_RST;
            for (int i = 0; i < NPROG; i++) begin
                succ[i] <= SUCC_NONE;
            end
        end else if (wr && paddr == A_CHAIN_ST) begin
            chain_start <= (pwdata[3:0] >= 4'(NPROG)) ? 4'(NPROG - 1)
                           : pwdata[3:0];
        end else if (wr && succ_hit) begin
            succ[succ_sel] <= (pwdata[3:0] > 4'(NPROG)) ? SUCC_NONE
                              : pwdata[3:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            active   <= ACTIVE_RST;
            limit_en <= 1'b0;
        end else if (wr && paddr == A_ACTIVE) begin
            active <= pwdata[NCH-1:0];
        end else if (wr && paddr == A_CTRL) begin
            limit_en <= pwdata[C_LIMIT_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencing engine.
    logic [10:0] on_end;
    logic [10:0] step_end;
    logic [10:0] sh_end;
    logic [10:0] pf_end;
    logic        tick_clr;

    assign on_end   = {1'b0, cur.on_t};
    assign step_end = on_end + {1'b0, cur.off_t};
    assign sh_end   = (cur.short_t > cur.on_t) ? on_end
                      : {1'b0, cur.short_t};
    assign pf_end   = (cur.pf_t == 10'h000) ? 11'h000
                      : ({1'b0, cur.pf_t} > step_end - 11'h001)
                      ? step_end - 11'h001 : {1'b0, cur.pf_t};
    assign tick_clr = !(state == ST_ON || state == ST_OFF);

    lps_tick #(
        .CYCLES (TICK_CYC)
    ) u_tick (
        .clock (clock),
        .rst_n (rst_n),
        .ce    (ce),
        .clr   (tick_clr),
        .tick  (tick)
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            t <= 11'h000;
        end else if (ce) begin
            if (tick_clr) begin
                t <= 11'h000;
            end else if (tick) begin
                t <= t + 11'h001;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            prog  <= 4'h0;
            step  <= 4'h0;
            cur   <= '0;
        end else if (ce) begin
            if (cmd_stop) begin
                state <= ST_IDLE;
            end else begin
                unique case (state)
                    ST_IDLE: begin
                        if (cmd_run && active != '0) begin
                            prog  <= chain_start;
                            step  <= 4'h0;
                            state <= ST_FETCH;
                        end
                    end
                    ST_FETCH: begin
                        cur <= steps[7'(prog) * 7'd10 + 7'(step)];
                        state <= ST_WAIT;
                    end
                    ST_WAIT: begin
                        if (cur.run == RUN_SKIP) begin
                            if (step == 4'(NSTEP - 1)) begin
                                if (succ[prog] == SUCC_NONE) begin
                                    state <= ST_IDLE;
                                end else begin
                                    prog  <= succ[prog] - 4'h1;
                                    step  <= 4'h0;
                                    state <= ST_FETCH;
                                end
                            end else begin
                                step  <= step + 4'h1;
                                state <= ST_FETCH;
                            end
                        end else if (cur.run == RUN_AUTO || cmd_cont) begin
                            state <= ST_ON;
                        end
                    end
                    ST_ON: begin
                        if (tick && t + 11'h001 >= on_end) begin
                            cur.run <= RUN_SKIP;
                            state <= (cur.off_t != 10'h000) ? ST_OFF
                                     : ST_WAIT;
                        end
                    end
                    ST_OFF: begin
                        if (tick && t + 11'h001 >= step_end) begin
                            cur.run <= RUN_SKIP;
                            state <= ST_WAIT;
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel outputs, registered.
    logic [NCH-1:0] sh_mask;

    generate
        for (genvar c = 0; c < NCH; c++) begin : g_sh
            assign sh_mask[c] = (cur.shch == 4'(c + 1));
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            chan_ctl <= '0;
            busy     <= 1'b0;
        end else if (ce) begin
            busy <= (state != ST_IDLE);
            chan_ctl.load_en <= (state == ST_ON) ? active : '0;
            chan_ctl.short_en <= (state == ST_ON && t < sh_end)
                                 ? (sh_mask & active) : '0;
            chan_ctl.settings_slot <= (state == ST_ON || state == ST_OFF)
                                      ? cur.slot : 7'h00;
            chan_ctl.judge_window <= limit_en
                && (state == ST_ON || state == ST_OFF)
                && (pf_end == 11'h000 || t < pf_end);
            chan_ctl.judge_strobe <= limit_en && pf_end != 11'h000
                && (state == ST_ON || state == ST_OFF)
                && tick && t + 11'h001 == pf_end;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            refused <= 1'b0;
        end else if (ce) begin
            if (state == ST_IDLE && cmd_run && active == '0) begin
                refused <= 1'b1;
            end else if (wr && paddr == A_STATUS && pwdata[S_REFUSED]) begin
                refused <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB read path: data is captured in the setup cycle.
    lps_step_s sel;

    assign sel    = steps[step_idx];
    assign pready = penable;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
            if (paddr == A_CTRL) begin
                prdata[C_LIMIT_EN] <= limit_en;
            end else if (paddr == A_ACTIVE) begin
                prdata[NCH-1:0] <= active;
            end else if (paddr == A_CHAIN_ST) begin
                prdata[3:0] <= chain_start;
            end else if (paddr == A_STEP_IDX) begin
                prdata[6:0] <= step_idx;
            end else if (paddr == A_STEP_W0) begin
                prdata[W0_SLOT_LO +: 7] <= sel.slot;
                prdata[W0_RUN_LO +: 2]  <= sel.run;
                prdata[W0_SHCH_LO +: 4] <= sel.shch;
            end else if (paddr == A_STEP_W1) begin
                prdata[9:0]            <= sel.on_t;
                prdata[W1_OFF_LO +: 10] <= sel.off_t;
            end else if (paddr == A_STEP_W2) begin
                prdata[9:0]            <= sel.short_t;
                prdata[W2_PF_LO +: 10] <= sel.pf_t;
            end else if (paddr == A_STATUS) begin
                prdata[S_BUSY]          <= (state != ST_IDLE);
                prdata[S_WAIT]          <= (state == ST_WAIT)
                                           && cur.run == RUN_MANUAL;
                prdata[S_OFFPH]         <= (state == ST_OFF);
                prdata[S_REFUSED]       <= refused;
                prdata[S_PROG_LO +: 4]  <= prog;
                prdata[S_STEP_LO +: 4]  <= step;
            end else if (succ_hit) begin
                prdata[3:0] <= succ[succ_sel];
            end else begin
                pslverr <= 1'b1;
            end
        end
    end

endmodule

/* File: tb/lps_checker.sv */
`timescale 1ns/10ps
module lps_checker
    import lps_pkg::*;
(
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        op_run,
    input wire logic        op_continue,
    input wire logic        op_stop,
    input wire lps_chan_s   chan_ctl,
    input wire logic        busy
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    sequence idle_two;
        !busy [*2];
    endsequence
    sequence stop_press;
        $rose(op_stop);
    endsequence
    sequence bad_read;
        psel && penable && !pwrite && paddr == 8'h20;
    endsequence

    zero_wait_a: assert property (pready == penable)
        else $error("pready does not follow penable");
    bad_addr_a: assert property (bad_read |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    good_addr_a: assert property (psel && penable && paddr == A_ACTIVE
        |-> !pslverr) else $error("mapped access flagged");
    idle_quiet_a: assert property (idle_two |->
        chan_ctl.load_en == 8'h00 && chan_ctl.short_en == 8'h00 &&
        !chan_ctl.judge_window && chan_ctl.settings_slot == 7'h00)
        else $error("idle outputs active");
    one_short_a: assert property ($onehot0(chan_ctl.short_en))
        else $error("more than one shorted channel");
    slot_range_a: assert property (chan_ctl.settings_slot <= SLOT_MAX)
        else $error("settings slot out of range");
    strobe_pulse_a: assert property (chan_ctl.judge_strobe
        |=> !chan_ctl.judge_strobe) else $error("judge strobe too long");
    stop_halt_a: assert property (stop_press |-> ##[1:8] !busy)
        else $error("stop did not halt");
    short_on_a: assert property (chan_ctl.short_en != 8'h00
        |-> chan_ctl.load_en != 8'h00) else $error("short outside on");
    short_seen_c: cover property (chan_ctl.short_en != 8'h00);
endmodule

/* File: tb/lps_oper.sv */
`timescale 1ns/10ps
module lps_oper
    import lps_pkg::*;
(
    input  wire lps_chan_s chan_ctl,
    input  wire logic      clock,
    output logic           op_run,
    output logic           op_continue,
    output logic           op_stop
);
    int          load_cyc;
    int          short_cyc;
    int          off_cyc;
    int          strobes;
    logic [7:0]  load_seen;
    logic [7:0]  short_seen;
    logic [6:0]  first_slot, last_slot;

    initial begin
        op_run = 1'b0;
        op_continue = 1'b0;
        op_stop = 1'b0;
    end

    // Pins are held six cycles so the two-flop synchroniser sees them.
    task automatic press(input int which);
        @(posedge clock);
        op_run <= (which == 0);
        op_continue <= (which == 1);
        op_stop <= (which == 2);
        repeat (6) @(posedge clock);
        op_run <= 1'b0;
        op_continue <= 1'b0;
        op_stop <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    task automatic clear();
        load_cyc = 0;
        short_cyc = 0;
        off_cyc = 0;
        strobes = 0;
        {load_seen, short_seen} = '0;
        {first_slot, last_slot} = '0;
    endtask

    always @(posedge clock) begin
        if (chan_ctl.load_en != 8'h00) begin
            load_cyc <= load_cyc + 1;
            load_seen <= chan_ctl.load_en;
        end else if (chan_ctl.settings_slot != 7'h00) begin
            off_cyc <= off_cyc + 1;
        end
        if (chan_ctl.short_en != 8'h00) begin
            short_cyc <= short_cyc + 1;
            short_seen <= chan_ctl.short_en;
        end
        if (chan_ctl.judge_strobe) begin
            strobes <= strobes + 1;
        end
        if (chan_ctl.settings_slot != 7'h00) begin
            last_slot <= chan_ctl.settings_slot;
            if (first_slot == 7'h00) begin
                first_slot <= chan_ctl.settings_slot;
            end
        end
    end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %0h got %0h", nm, (e), (g)); end end
module tb_top
    import lps_pkg::*;
;
    localparam int TK = 10;
    logic        clock, resetn, ce, psel, penable, pwrite, pready, pslverr;
    logic        op_run, op_continue, op_stop, busy, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    lps_chan_s   chan_ctl;
    int          fails, n_checks, p, on, off, sh, c, pf, s1, s2, act;

    lps_seq #(.TICK_CYC(TK)) dut (.clock(clock), .resetn(resetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .op_run(op_run), .op_continue(op_continue),
        .op_stop(op_stop), .chan_ctl(chan_ctl), .busy(busy));
    lps_oper oper (.chan_ctl(chan_ctl), .clock(clock), .op_run(op_run),
        .op_continue(op_continue), .op_stop(op_stop));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic final_report();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 20) begin
            fails++;
            final_report();
        end
        @(posedge clock);
    endtask

    task automatic set_step(input int i, s, r, t_on, t_off, t_sh, ch, t_pf);
        apb(1'b1, A_STEP_IDX, 32'(i));
        apb(1'b1, A_STEP_W0, 32'(s) | 32'(r) << W0_RUN_LO
            | 32'(ch) << W0_SHCH_LO);
        apb(1'b1, A_STEP_W1, 32'(t_on) | 32'(t_off) << W1_OFF_LO);
        apb(1'b1, A_STEP_W2, 32'(t_sh) | 32'(t_pf) << W2_PF_LO);
    endtask

    task automatic wait_idle();
        int k;
        repeat (8) @(posedge clock);
        for (k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge clock);
        if (k == 2000) begin
            fails++;
            final_report();
        end
    endtask

    function automatic logic near(input int g, e, t);
        return g >= e - t && g <= e + t;
    endfunction

    function automatic logic [7:0] ch_mask(input int ch);
        return ch == 0 ? 8'h00 : 8'h01 << (ch - 1);
    endfunction

    initial begin
        {resetn, ce, psel, penable, pwrite, paddr, pwdata} = '0;
        fails = 0;
        n_checks = 0;
        void'($urandom(32'h2c584c56));
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        ce <= 1'b1;
        repeat (3) @(posedge clock);
        apb(1'b0, A_ACTIVE, 32'h0);
        `CHK("active_rst", 32'h0, rd)
        apb(1'b0, A_CHAIN_ST, 32'h0);
        `CHK("start_rst", 32'h0, rd)
        apb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped_err", 1'b1, err)
        apb(1'b1, A_CTRL, 32'h1 << C_RUN);
        repeat (8) @(posedge clock);
        `CHK("refused_busy", 1'b0, busy)
        apb(1'b0, A_STATUS, 32'h0);
        `CHK("refused_flag", 1'b1, rd[S_REFUSED])
        set_step(5, 9, RUN_AUTO, 3, 0, 0, 0, 0);
        apb(1'b1, A_CTRL, 32'h1 << C_PDEF);
        apb(1'b0, A_STEP_W0, 32'h0);
        `CHK("pdef_clear", 32'h0, rd)
        $display("test registers done");
        for (int i = 0; i < 3; i++) begin
            p = $urandom_range(11);
            on = $urandom_range(5, 2);
            off = $urandom_range(3);
            sh = $urandom_range(on + 2);
            c = $urandom_range(8);
            pf = $urandom_range(on + off + 3, 1);
            s1 = $urandom_range(120, 1);
            s2 = $urandom_range(120, 1);
            act = $urandom_range(255, 1);
            if (i == 0) begin
                sh = on + 2;
                c = 8;
            end
            apb(1'b1, A_CTRL, 32'h1 << C_PDEF | 32'h1 << C_CDEF);
            set_step(p * 10, s1, RUN_AUTO, on, off, sh, c, pf);
            set_step(p * 10 + 9, s2, RUN_AUTO, on, off, sh, c, pf);
            apb(1'b1, A_ACTIVE, 32'(act));
            apb(1'b1, A_CHAIN_ST, 32'(p));
            oper.clear();
            apb(1'b1, A_CTRL, 32'h1 << C_RUN | 32'h1 << C_LIMIT_EN);
            wait_idle();
            `CHK("first_slot", 7'(s1), oper.first_slot)
            `CHK("last_slot", 7'(s2), oper.last_slot)
            `CHK("load_mask", 8'(act), oper.load_seen)
            `CHK("on_time", 1'b1, near(oper.load_cyc, 2*on*TK, 3))
            `CHK("off_time", 1'b1, near(oper.off_cyc, 2*off*TK, 8))
            `CHK("shorted_channel_select", ch_mask(sh ? c : 0) & 8'(act),
                oper.short_seen)
            `CHK("short_t", 1'b1, near(oper.short_cyc,
                ch_mask(c) & 8'(act) ? 2 * (sh > on ? on : sh) * TK : 0, 3))
            `CHK("strobes", 2, oper.strobes)
        end
        $display("test random runs done");
        apb(1'b1, A_CTRL, 32'h1 << C_PDEF | 32'h1 << C_CDEF);
        set_step(0, 7, RUN_MANUAL, 1, 0, 0, 0, 0);
        apb(1'b1, A_CHAIN_NEXT, 32'h1);
        apb(1'b1, A_ACTIVE, 32'h81);
        oper.clear();
        oper.press(0);
        repeat (20) @(posedge clock);
        `CHK("manual_busy", 1'b1, busy)
        `CHK("manual_hold", 0, oper.load_cyc)
        oper.press(1);
        repeat (30) @(posedge clock);
        `CHK("cont_load", 1'b1, near(oper.load_cyc, TK, 3))
        apb(1'b0, A_STATUS, 32'h0);
        `CHK("loop_wait", 1'b1, rd[S_WAIT])
        oper.press(2);
        `CHK("stop_idle", 1'b0, busy)
        apb(1'b1, A_CHAIN_ST, 32'hf);
        apb(1'b0, A_CHAIN_ST, 32'h0);
        `CHK("start_clamp", 32'hb, rd)
        apb(1'b1, A_CTRL, 32'h1 << C_CDEF);
        apb(1'b0, A_CHAIN_ST, 32'h0);
        `CHK("cdef_start", 32'h0, rd)
        apb(1'b0, A_CHAIN_NEXT, 32'h0);
        `CHK("cdef_succ", 32'h0, rd)
        $display("test manual chain done");
        final_report();
    end
endmodule

bind lps_seq lps_checker chk (.clock(clock), .resetn(resetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_run(op_run), .op_continue(op_continue), .op_stop(op_stop),
    .chan_ctl(chan_ctl), .busy(busy));
